/* File: inc/mpp_regs.svh */
// Register offsets, field positions and timing counts of the program port controller.
`ifndef MPP_REGS_SVH
`define MPP_REGS_SVH
// ----------------------------------------
// APB register offsets
// ----------------------------------------
`define MPP_OFF_CTRL 8'h00
`define MPP_OFF_ADDR 8'h04
`define MPP_OFF_WDATA 8'h08
`define MPP_OFF_CHECK 8'h0C
`define MPP_OFF_STAT 8'h10
`define MPP_OFF_RDATA 8'h14
`define MPP_OFF_DIV 8'h18
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define MPP_CTRL_GO 0
`define MPP_CTRL_CMD_LO 1
`define MPP_CTRL_CMD_HI 2
`define MPP_STAT_BUSY 0
`define MPP_STAT_DONE 1
`define MPP_STAT_NVDONE 2
`define MPP_STAT_RXERR 3
`define MPP_STAT_NVTMO 4
`define MPP_DIV_RESET 20'h0_00FA
`define MPP_ACCESS_ADDR 6'h24
`define MPP_ACCESS_CODE 30'h2C41_3737
// ----------------------------------------
// Frame lengths in bits
// ----------------------------------------
`define MPP_TX_WRITE_BITS 6'h2A
`define MPP_TX_READ_BITS 6'h0C
`define MPP_RX_BITS 6'h20
// ----------------------------------------
// Timing
// ----------------------------------------
`define MPP_CLK_MHZ 40
`define MPP_DRIVE_LOW_US 15
`define MPP_RESUME_US 125
`define MPP_NVWRITE_MS 20
`define MPP_DRIVE_LOW_CYC (`MPP_DRIVE_LOW_US * `MPP_CLK_MHZ)
`endif

/* File: inc/mpp_pkg.sv */
// Types shared by the program port controller and its bench.
package mpp_pkg;
  typedef enum logic [1:0] {
    CMD_ACCESS,
    CMD_VOL_WRITE,
    CMD_NV_WRITE,
    CMD_READ
  } mpp_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_SEND,
    ST_NVWAIT,
    ST_RXFIRST,
    ST_RXBIT,
    ST_END,
    ST_RESUME
  } mpp_state_t;
  typedef struct packed {
    logic pgmEn;
    logic lineOut;
    logic lineOeN;
  } mpp_pins_t;
endpackage

/* File: src/mpp_host.sv */
// Controller that programs the sensor over its supply and output pins.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "mpp_regs.svh"
module mpp_host #(
  parameter int unsigned ResumeCycles = `MPP_RESUME_US * `MPP_CLK_MHZ,
  parameter int unsigned NvWaitCycles = 2 * `MPP_NVWRITE_MS * 1000 * `MPP_CLK_MHZ
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lineIn,
  output mpp_pkg::mpp_pins_t pins
);
  import mpp_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  mpp_state_t state_reg, state_next;
  mpp_cmd_t cmd_reg, cmd_next;
  logic [5:0] addr_reg, addr_next;
  logic [29:0] wdata_reg, wdata_next;
  logic [2:0] check_reg, check_next;
  logic [19:0] div_reg, div_next;
  logic [29:0] rdata_reg, rdata_next;
  logic done_reg, done_next;
  logic nvDone_reg, nvDone_next;
  logic rxErr_reg, rxErr_next;
  logic nvTmo_reg, nvTmo_next;
  logic [23:0] tmr_reg, tmr_next;
  logic [41:0] shift_reg, shift_next;
  logic [5:0] bitCnt_reg, bitCnt_next;
  logic phase_reg, phase_next;
  logic [31:0] rxShift_reg, rxShift_next;
  mpp_pins_t pins_reg, pins_next;
  logic [31:0] prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic sync1_reg, sync2_reg, sync3_reg, lvl_reg, lvl_next;
  logic agree, rise, fall, wrEn, go;
  logic [23:0] half, blank;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic known(input logic [7:0] a);
    known = (a == `MPP_OFF_CTRL) || (a == `MPP_OFF_ADDR) ||
      (a == `MPP_OFF_WDATA) || (a == `MPP_OFF_CHECK) ||
      (a == `MPP_OFF_STAT) || (a == `MPP_OFF_RDATA) ||
      (a == `MPP_OFF_DIV);
  endfunction

  function automatic logic [23:0] wrap(input logic [23:0] t);
    wrap = t + 24'h00_0001;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    check_next = check_reg;
    div_next = div_reg;
    rdata_next = rdata_reg;
    done_next = done_reg;
    nvDone_next = nvDone_reg;
    rxErr_next = rxErr_reg;
    nvTmo_next = nvTmo_reg;
    tmr_next = tmr_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    phase_next = phase_reg;
    rxShift_next = rxShift_reg;
    pins_next = pins_reg;
    // A line level counts once the two later stages agree.
    agree = (sync2_reg == sync3_reg);
    lvl_next = agree ? sync3_reg : lvl_reg;
    rise = agree && sync3_reg && !lvl_reg;
    fall = agree && !sync3_reg && lvl_reg;
    half = {4'h0, div_reg};
    blank = half + {5'h00, div_reg[19:1]};
    // APB slave, one wait state.
    pready_next = psel && penable && !pready_reg;
    pslverr_next = psel && penable && !pready_reg && !known(paddr);
    wrEn = psel && penable && pready_reg && pwrite;
    go = wrEn && (paddr == `MPP_OFF_CTRL) && pwdata[`MPP_CTRL_GO];
    prdata_next = 32'h0000_0000;
    unique case (paddr)
      `MPP_OFF_CTRL: prdata_next = {29'h0000_0000, cmd_reg, 1'b0};
      `MPP_OFF_ADDR: prdata_next = {26'h000_0000, addr_reg};
      `MPP_OFF_WDATA: prdata_next = {2'b00, wdata_reg};
      `MPP_OFF_CHECK: prdata_next = {29'h0000_0000, check_reg};
      `MPP_OFF_STAT: prdata_next = {27'h000_0000, nvTmo_reg, rxErr_reg,
        nvDone_reg, done_reg, state_reg != ST_IDLE};
      `MPP_OFF_RDATA: prdata_next = {2'b00, rdata_reg};
      `MPP_OFF_DIV: prdata_next = {12'h000, div_reg};
      default: prdata_next = 32'h0000_0000;
    endcase
    if (wrEn && state_reg == ST_IDLE) begin
      unique case (paddr)
        `MPP_OFF_CTRL: cmd_next = mpp_cmd_t'(pwdata[`MPP_CTRL_CMD_HI:`MPP_CTRL_CMD_LO]);
        `MPP_OFF_ADDR: addr_next = pwdata[5:0];
        `MPP_OFF_WDATA: wdata_next = pwdata[29:0];
        `MPP_OFF_CHECK: check_next = pwdata[2:0];
        `MPP_OFF_DIV: div_next = pwdata[19:0];
        default: ;
      endcase
    end
    // Status flags clear on writing one; a hardware set in the same cycle wins.
    if (wrEn && paddr == `MPP_OFF_STAT) begin
      done_next = done_reg && !pwdata[`MPP_STAT_DONE];
      nvDone_next = nvDone_reg && !pwdata[`MPP_STAT_NVDONE];
      rxErr_next = rxErr_reg && !pwdata[`MPP_STAT_RXERR];
      nvTmo_next = nvTmo_reg && !pwdata[`MPP_STAT_NVTMO];
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (go) begin
          // Only software starts a frame; the device is never waited on here.
          pins_next.pgmEn = 1'b1;
          pins_next.lineOut = 1'b0;
          pins_next.lineOeN = 1'b0;
          tmr_next = 24'h00_0000;
          state_next = ST_LEAD;
          unique case (mpp_cmd_t'(pwdata[`MPP_CTRL_CMD_HI:`MPP_CTRL_CMD_LO]))
            CMD_ACCESS: begin
              shift_next = {2'b00, 1'b0, `MPP_ACCESS_ADDR, `MPP_ACCESS_CODE, check_reg};
              bitCnt_next = `MPP_TX_WRITE_BITS;
            end
            CMD_READ: begin
              shift_next = {2'b00, 1'b1, addr_reg, check_reg, 30'h0000_0000};
              bitCnt_next = `MPP_TX_READ_BITS;
            end
            default: begin
              // Upper six data bits are don't care, sent as zero.
              shift_next = {2'b00, 1'b0, addr_reg, 6'h00, wdata_reg[23:0], check_reg};
              bitCnt_next = `MPP_TX_WRITE_BITS;
            end
          endcase
        end
      end
      ST_LEAD: begin
        // Line has been low since enable rose; start bits at the deadline.
        tmr_next = wrap(tmr_reg);
        if (tmr_reg == 24'(`MPP_DRIVE_LOW_CYC - 1)) begin
          tmr_next = 24'h00_0000;
          phase_next = 1'b0;
          pins_next.lineOut = shift_reg[41];
          state_next = ST_SEND;
        end
      end
      ST_SEND: begin
        tmr_next = wrap(tmr_reg);
        if (tmr_reg == half - 24'h00_0001) begin
          tmr_next = 24'h00_0000;
          if (!phase_reg) begin
            phase_next = 1'b1;
            pins_next.lineOut = !shift_reg[41];
          end else begin
            phase_next = 1'b0;
            shift_next = {shift_reg[40:0], 1'b0};
            bitCnt_next = bitCnt_reg - 6'h01;
            pins_next.lineOut = shift_reg[40];
            if (bitCnt_reg == 6'h01) begin
              // Release the line so the device may answer or signal.
              pins_next.lineOeN = 1'b1;
              pins_next.lineOut = 1'b0;
              unique case (cmd_reg)
                CMD_READ: state_next = ST_RXFIRST;
                CMD_NV_WRITE: state_next = ST_NVWAIT;
                default: state_next = ST_END;
              endcase
            end
          end
        end
      end
      ST_NVWAIT: begin
        tmr_next = wrap(tmr_reg);
        if (fall) begin
          nvDone_next = 1'b1;
          state_next = ST_END;
        end else if (tmr_reg == 24'(NvWaitCycles - 1)) begin
          nvTmo_next = 1'b1;
          state_next = ST_END;
        end
      end
      ST_RXFIRST: begin
        // First sync bit shows as a rise at its middle.
        tmr_next = wrap(tmr_reg);
        // A rise inside the first half bit is the released line settling, not the answer.
        if (rise && tmr_reg >= half) begin
          tmr_next = 24'h00_0000;
          rxShift_next = 32'h0000_0000;
          bitCnt_next = `MPP_RX_BITS - 6'h01;
          state_next = ST_RXBIT;
        end else if (tmr_reg == {div_reg, 4'h0}) begin
          rxErr_next = 1'b1;
          state_next = ST_END;
        end
      end
      ST_RXBIT: begin
        // Edges before three quarters of a bit are bit-boundary edges.
        tmr_next = wrap(tmr_reg);
        if (tmr_reg >= blank && (rise || fall)) begin
          tmr_next = 24'h00_0000;
          rxShift_next = {rxShift_reg[30:0], fall};
          bitCnt_next = bitCnt_reg - 6'h01;
          if (bitCnt_reg == 6'h01) begin
            rdata_next = {rxShift_reg[28:0], fall};
            if (rxShift_reg[30:29] != 2'b00) rxErr_next = 1'b1;
            state_next = ST_END;
          end
        end else if (tmr_reg == half + blank) begin
          rxErr_next = 1'b1;
          state_next = ST_END;
        end
      end
      ST_END: begin
        // Only one frame per enable pulse, so enable always drops here.
        pins_next.pgmEn = 1'b0;
        pins_next.lineOeN = 1'b1;
        tmr_next = 24'h00_0000;
        state_next = ST_RESUME;
      end
      ST_RESUME: begin
        // Waiting out the resume delay keeps a quick next command from
        // meeting the device while it still drives its output.
        tmr_next = wrap(tmr_reg);
        if (tmr_reg == 24'(ResumeCycles - 1)) begin
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      cmd_reg <= CMD_ACCESS;
      addr_reg <= 6'h00;
      wdata_reg <= 30'h0000_0000;
      check_reg <= 3'h0;
      div_reg <= `MPP_DIV_RESET;
      rdata_reg <= 30'h0000_0000;
      done_reg <= 1'b0;
      nvDone_reg <= 1'b0;
      rxErr_reg <= 1'b0;
      nvTmo_reg <= 1'b0;
      tmr_reg <= 24'h00_0000;
      shift_reg <= 42'h000_0000_0000;
      bitCnt_reg <= 6'h00;
      phase_reg <= 1'b0;
      rxShift_reg <= 32'h0000_0000;
      pins_reg <= 3'b001;
      prdata <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      // Start at the pulled-up idle level so leaving reset shows no false edge.
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
      lvl_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      check_reg <= check_next;
      div_reg <= div_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      nvDone_reg <= nvDone_next;
      rxErr_reg <= rxErr_next;
      nvTmo_reg <= nvTmo_next;
      tmr_reg <= tmr_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      phase_reg <= phase_next;
      rxShift_reg <= rxShift_next;
      pins_reg <= pins_next;
      prdata <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      sync1_reg <= lineIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pins = pins_reg;
endmodule // mpp_host

/* File: bench/mpp_host_assertions.sv */
// Port checker for the program port controller, bound to its top module.
`timescale 1ns/1ps
// ----------------------------------------
// Checker
// ----------------------------------------
module mpp_host_assertions (
  input logic clk,
  input logic srst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic lineIn,
  input mpp_pkg::mpp_pins_t pins
);
  import mpp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("access phase length wrong");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  slverr_read_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0000_0000))
    else $error("bad error response");
  drive_low_a: assert property ($rose(pins.pgmEn) |-> !pins.lineOeN && !pins.lineOut)
    else $error("line not pulled low at enable");
  sync_lead_a: assert property ($rose(pins.pgmEn) |=> (!pins.lineOeN && !pins.lineOut) [*8])
    else $error("lead low not held");
  drive_mode_a: assert property (!pins.lineOeN |-> pins.pgmEn)
    else $error("line driven outside program mode");
  release_drop_a: assert property ($fell(pins.pgmEn) |-> $past(pins.lineOeN))
    else $error("enable dropped while driving");
  one_frame_a: assert property ($fell(pins.lineOeN) |-> $rose(pins.pgmEn))
    else $error("line driven again within one enable pulse");
  enable_gap_a: assert property ($fell(pins.pgmEn) |=> !pins.pgmEn [*8])
    else $error("enable gap too short");
  cover property ($rose(pins.pgmEn));
  cover property (pslverr);
  cover property ($fell(lineIn) && pins.lineOeN);
endmodule // mpp_host_assertions

bind mpp_host mpp_host_assertions i_mpp_host_assertions (.clk, .srst, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .lineIn, .pins);

/* File: bench/mpp_dev_model.sv */
// Behavioural model of the sensor side of the programming port.
`timescale 1ns/1ps
// ----------------------------------------
// Sensor model
// ----------------------------------------
module mpp_dev_model #(
  parameter int Half = 4,
  parameter int NvDelay = 100
) (
  input logic clk,
  input mpp_pkg::mpp_pins_t pins,
  input logic line,
  output logic devDrv,
  output logic devOut,
  output int frames,
  output int bad,
  output int clash
);
  import mpp_pkg::*;
  logic [29:0] mem [64];
  logic [41:0] f;
  logic [31:0] ack;
  logic [5:0] a;
  logic unl;
  int n, len;
  // Six check bits stored beside each word; the mask pattern is arbitrary.
  function automatic logic [5:0] ham(input logic [23:0] d);
    for (int i = 0; i < 6; i++) ham[i] = ^(d & (24'h5A_5A5A >> i));
  endfunction
  always @(posedge clk) if (devDrv && !pins.lineOeN) clash <= clash + 1;
  initial begin
    devDrv = 1'h0;
    devOut = 1'h1;
    unl = 1'h0;
    frames = 0;
    bad = 0;
    clash = 0;
    foreach (mem[i]) mem[i] = 30'h0000_0000;
    forever begin
      @(posedge pins.pgmEn);
      devDrv <= 1'h0;
      @(posedge line);
      repeat (Half / 2) @(posedge clk);
      f = {41'h0, ~line};
      len = 42;
      for (n = 1; n < len; n++) begin
        repeat (2 * Half) @(posedge clk);
        f = {f[40:0], ~line};
        if (n == 2 && f[0]) len = 12;
      end
      frames++;
      if (len == 12) begin
        a = f[8:3];
        if (f[11:10] != 2'h0) bad++;
        else if (unl) begin
          ack = {2'h0, mem[a][29:26], 2'h0, mem[a][23:0]};
          repeat (2 * Half) @(posedge clk);
          devDrv <= 1'h1;
          for (n = 31; n >= 0; n--) begin
            devOut <= ack[n];
            repeat (Half) @(posedge clk);
            devOut <= ~ack[n];
            repeat (Half) @(posedge clk);
          end
          devDrv <= 1'h0;
        end
      end else begin
        a = f[38:33];
        // A frame with broken sync is dropped whole.
        if (f[41:40] != 2'h0) bad++;
        else if (a == 6'h24 && f[32:3] == 30'h2C41_3737) unl = 1'h1;
        else if (unl) begin
          mem[a] = {ham(f[26:3]), f[26:3]};
          if (!a[5]) begin
            repeat (NvDelay) @(posedge clk);
            devOut <= 1'h0;
            devDrv <= 1'h1;
            repeat (2) @(posedge clk);
            devDrv <= 1'h0;
          end
        end
      end
      @(negedge pins.pgmEn);
      devOut <= 1'h1;
      devDrv <= 1'h1;
    end
  end
endmodule // mpp_dev_model

/* File: bench/mpp_host_tb.sv */
// Self-checking bench for the program port controller.
`timescale 1ns/1ps
`include "mpp_regs.svh"
// ----------------------------------------
// Bench top
// ----------------------------------------
module mpp_host_tb;
  import mpp_pkg::*;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, devDrv, devOut, err, unl;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic [5:0] a;
  logic [23:0] expMem [64];
  mpp_pins_t pins;
  // The line has a pull-up, so a released line reads high rather than a stale value.
  wire line = !pins.lineOeN ? pins.lineOut : (devDrv ? devOut : 1'h1);
  int fail_count, tests_run, frames, bad, clash, seed, nCmd;
  mpp_host #(.ResumeCycles(20), .NvWaitCycles(2000)) i_mpp_host (.clk, .srst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .lineIn(line), .pins);
  mpp_dev_model i_mpp_dev_model (.clk, .pins, .line, .devDrv, .devOut, .frames, .bad, .clash);
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k >= 20) check(32'h0000_0000, 32'h0000_0001);
    if (k >= 20) results();
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic run(input mpp_cmd_t c, input logic [5:0] ca, input logic [29:0] d);
    int k;
    logic [4:0] es;
    rnd = $random(seed);
    apb(1'h1, `MPP_OFF_ADDR, {26'h0, ca});
    apb(1'h1, `MPP_OFF_WDATA, {2'h0, d});
    apb(1'h1, `MPP_OFF_CHECK, {29'h0, rnd[2:0]});
    apb(1'h1, `MPP_OFF_CTRL, {29'h0, c, 1'h1});
    apb(1'h1, `MPP_OFF_ADDR, {26'h0, ~ca});
    k = 0;
    do begin
      apb(1'h0, `MPP_OFF_STAT, 32'h0000_0000);
      k++;
    end while (rd[0] !== 1'h0 && k < 3000);
    if (k >= 3000) check(32'h0000_0000, 32'h0000_0001);
    if (k >= 3000) results();
    es = 5'h02;
    if (c == CMD_READ && !unl) es[3] = 1'h1;
    if (c == CMD_NV_WRITE) es[2] = 1'h1;
    if (c == CMD_ACCESS) unl = 1'h1;
    else if (c != CMD_READ) expMem[ca] = d[23:0];
    check({27'h0, rd[4:0]}, {27'h0, es});
    apb(1'h0, `MPP_OFF_ADDR, 32'h0000_0000);
    check(rd, {26'h0, ca});
    if (c == CMD_READ && unl) begin
      apb(1'h0, `MPP_OFF_RDATA, 32'h0000_0000);
      check({6'h0, rd[25:0]}, {8'h00, expMem[ca]});
    end
    apb(1'h1, `MPP_OFF_STAT, 32'h0000_001E);
    nCmd++;
  endtask
  initial begin
    srst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fail_count = 0;
    tests_run = 0;
    nCmd = 0;
    unl = 1'h0;
    seed = 32'h0000_0013;
    foreach (expMem[i]) expMem[i] = 24'h00_0000;
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    repeat (2) @(posedge clk);
    apb(1'h0, `MPP_OFF_STAT, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'h0, `MPP_OFF_DIV, 32'h0000_0000);
    check(rd, 32'h0000_00FA);
    apb(1'h0, 8'h1C, 32'h0000_0000);
    check({err, rd[30:0]}, 32'h8000_0000);
    apb(1'h1, `MPP_OFF_DIV, 32'h0000_0004);
    apb(1'h0, `MPP_OFF_DIV, 32'h0000_0000);
    check(rd, 32'h0000_0004);
    // A read while still locked gets no answer and must end in a receive error.
    run(CMD_READ, 6'h22, 30'h0000_0000);
    run(CMD_ACCESS, 6'h15, 30'h0BAD_F00D);
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      a = (rnd[5:0] == 6'h24) ? 6'h25 : rnd[5:0];
      run(a[5] ? CMD_VOL_WRITE : CMD_NV_WRITE, a, $random(seed));
      run(CMD_READ, a, 30'h0000_0000);
    end
    check(frames, nCmd);
    check(bad, 0);
    check(clash, 0);
    results();
  end
endmodule // mpp_host_tb
